/* File: pkg/afp_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, classic Wishbone with 32-bit data
// Notes:   Included by bare name; definitions only
`ifndef AFP_REGS_SVH
`define AFP_REGS_SVH
// -------------------------------------------------
// Register byte offsets
// -------------------------------------------------
`define AFP_OFS_CTRL     4'h0
`define AFP_OFS_STATUS   4'h4
`define AFP_OFS_FAULT    4'h8
`define AFP_OFS_PROT     4'hC
// -------------------------------------------------
// Control fields and reset value
// -------------------------------------------------
`define AFP_CTRL_EN      0
`define AFP_CTRL_FOLDDIS 1
`define AFP_CTRL_RST     2'h1
// -------------------------------------------------
// Fault bit positions (status 8..13, sticky 0..5)
// -------------------------------------------------
`define AFP_F_OTP        0
`define AFP_F_UV         1
`define AFP_F_OV         2
`define AFP_F_UBAL       3
`define AFP_F_CLK        4
`define AFP_F_OCP        5
`define AFP_NFLT         6
// -------------------------------------------------
// Timing
// -------------------------------------------------
`define AFP_CLK_HZ       20000000
`define AFP_T_RESTART_MS 100
`define AFP_RESTART_CYC  (`AFP_T_RESTART_MS * (`AFP_CLK_HZ / 1000))
`define AFP_T_CLKLOSS_NS 10000
`define AFP_CLKLOSS_CYC  ((`AFP_T_CLKLOSS_NS * (`AFP_CLK_HZ / 1000000)) / 1000)
`define AFP_T_FOLD_US    1000
`define AFP_FOLD_CYC     (`AFP_T_FOLD_US * (`AFP_CLK_HZ / 1000000))
// -------------------------------------------------
// Gain reduction and fault integrator
// -------------------------------------------------
`define AFP_ATTEN_MAX    4'hC
`define AFP_PROT_FULL    8'hFF
`define AFP_PROT_DRAIN   8'h20
`define AFP_PROT_CHARGE  8'h08
`define AFP_NPIN         14
`endif

/* File: pkg/afp_pkg.sv */
// Purpose: Types shared by the fault protection manager
// Assumes: Nothing beyond SystemVerilog 2012
// Notes:   Constants live in afp_regs.svh
package afp_pkg;
   // Supervisor states
   typedef enum logic [1:0] {
      ST_STBY  = 2'b00,
      ST_DELAY = 2'b01,
      ST_CHECK = 2'b10,
      ST_RUN   = 2'b11
   } afp_state_t;
endpackage

/* File: verilog/afp_top.sv */
// Purpose: Fault protection manager for a two-channel switching amplifier
// Assumes: Fault pins are asynchronous levels; rail magnitudes come from
//          a converter clocked by clk_i
// Notes:   Power stages only run in ST_RUN; all restarts wait one delay
//
// Overview of operation
// - Ramp gain down inside foldback temperature band
// - Attenuation reaches at least six dB
// - Foldback disable leaves only overtemperature shutdown
// - Shutdown at limit, restart 100 ms later
// - One overcurrent detector per power switch
// - High impedance overload clips, keeps switching
// - Event swaps switches, drains integrator partly
// - Drained integrator shuts down, starts timer
// - Retry every 100 ms until overcurrent clears
// - Check rail shorts before enabling stages
// - Repeat rail short check on retries
// - Undervoltage shuts down, restarts 100 ms later
// - Overvoltage stops stages, restarts 100 ms later
// - Rail imbalance over factor two faults
// - Lost or slow carrier keeps amplifier off
// - Clock return restarts after full delay
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "afp_regs.svh"
module afp_top
   import afp_pkg::*;
#(
   parameter int RESTART_CYC = `AFP_RESTART_CYC,
   parameter int FOLD_CYC    = `AFP_FOLD_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Sensing pins (asynchronous)
   input  wire logic        temp_fold_i,
   input  wire logic        temp_shut_i,
   input  wire logic [3:0]  oc_i,
   input  wire logic        low_z_i,
   input  wire logic [1:0]  rail_short_i,
   input  wire logic        uv_i,
   input  wire logic        ov_i,
   input  wire logic        mode_run_i,
   input  wire logic        fold_dis_i,
   input  wire logic        carrier_i,
   // Rail magnitudes (same clock)
   input  wire logic [7:0]  positive_analog_rail_i,
   input  wire logic [7:0]  negative_analog_rail_i,
   // Power stage control
   output logic             stage_en_o,
   output logic [3:0]       force_off_o,
   output logic [3:0]       force_on_o,
   output logic [3:0]       gain_atten_o
);
   // -------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------
   logic [`AFP_NPIN-1:0] pin_raw;   // Packed pin vector
   logic [`AFP_NPIN-1:0] meta_ff;   // First stage, read only by sync_ff
   logic [`AFP_NPIN-1:0] sync_ff;   // Second stage, safe to use
   assign pin_raw = {carrier_i, fold_dis_i, mode_run_i, ov_i, uv_i,
                     rail_short_i, low_z_i, oc_i, temp_shut_i, temp_fold_i};
   // Two flops per pin
   genvar g;
   generate
      for (g = 0; g < `AFP_NPIN; g++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_ff[g] <= 1'b0;
               sync_ff[g] <= 1'b0;
            end else begin
               meta_ff[g] <= pin_raw[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate
   logic       s_fold;              // Above foldback level
   logic       s_shut;              // Above shutdown level
   logic [3:0] s_oc;                // Per switch overcurrent
   logic       s_lowz;              // Fault below impedance threshold
   logic [1:0] s_short;             // Output tied to a rail
   logic       s_uv;                // Under-voltage
   logic       s_ov;                // Over-voltage
   logic       s_run;               // Mode pin out of standby
   logic       s_fdis;              // Mode pin foldback disable
   logic       s_car;               // Carrier clock level
   assign {s_car, s_fdis, s_run, s_ov, s_uv, s_short, s_lowz, s_oc, s_shut, s_fold} = sync_ff;
   // -------------------------------------------------
   // Registers and shared state
   // -------------------------------------------------
   logic [1:0]             ctrl_ff;      // Enable, software foldback disable
   logic [`AFP_NFLT-1:0]   sticky_ff;    // Fault history, write one to clear
   afp_state_t             state_ff;     // Supervisor state
   afp_state_t             nxt_state;
   logic [7:0]             prot_ff;      // Fault integrator level
   logic [3:0]             atten_ff;     // Gain reduction in dB
   logic [3:0]             oc_prev_ff;   // Overcurrent edge detect
   logic                   car_prev_ff;  // Carrier edge detect
   logic [7:0]             loss_cnt_ff;  // Cycles since last carrier edge
   logic                   clk_lost_ff;  // Carrier missing or slow
   logic [20:0]            rst_cnt_ff;   // Restart delay counter
   logic [14:0]            fold_cnt_ff;  // Foldback step pacing
   logic                   ubal_ff;      // Rail imbalance registered
   logic                   stage_en_ff;
   logic [3:0]             force_off_ff;
   logic [31:0]            rdat_ff;
   logic                   ack_ff;
   logic                   car_edge;     // Start of switching cycle
   logic [3:0]             oc_evt;       // New overcurrent events
   logic                   fault_any;    // Any shutdown fault present
   logic                   ocp_trip;     // Integrator fully drained
   logic                   delay_done;
   logic                   fold_off;
   logic [`AFP_NFLT-1:0]   flt_now;
   logic                   wr_hit;
   assign car_edge   = s_car & ~car_prev_ff;
   assign oc_evt     = s_oc & ~oc_prev_ff;
   assign ocp_trip   = (state_ff == ST_RUN) && (prot_ff == 8'h00);
   assign delay_done = (rst_cnt_ff == 21'(RESTART_CYC - 1));
   assign fold_off   = s_fdis | ctrl_ff[`AFP_CTRL_FOLDDIS];
   assign fault_any  = s_shut | s_uv | s_ov | ubal_ff | clk_lost_ff;
   assign flt_now    = {ocp_trip, clk_lost_ff, ubal_ff, s_ov, s_uv, s_shut};
   assign wr_hit     = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
   // -------------------------------------------------
   // Rail imbalance and carrier supervision
   // -------------------------------------------------
   // factor two comparison
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ubal_ff <= 1'b0;
      end else begin
         ubal_ff <= ({1'b0, positive_analog_rail_i} > {negative_analog_rail_i, 1'b0}) ||
                    ({1'b0, negative_analog_rail_i} > {positive_analog_rail_i, 1'b0});
      end
   end
   // Carrier edge watchdog; a slow carrier also times out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         car_prev_ff <= 1'b0;
         loss_cnt_ff <= 8'h00;
         clk_lost_ff <= 1'b1;
      end else begin
         car_prev_ff <= s_car;
         if (car_edge) begin
            loss_cnt_ff <= 8'h00;
            clk_lost_ff <= 1'b0;
         end else if (loss_cnt_ff == 8'(`AFP_CLKLOSS_CYC - 1)) begin
            clk_lost_ff <= 1'b1;
         end else begin
            loss_cnt_ff <= loss_cnt_ff + 8'h01;
         end
      end
   end
   // -------------------------------------------------
   // Restart delay and supervisor
   // -------------------------------------------------
   // Counter runs only with every fault clear and start-up requested
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_cnt_ff <= 21'h000000;
      end else if (state_ff != ST_DELAY || fault_any || !s_run) begin
         rst_cnt_ff <= 21'h000000;
      end else if (!delay_done) begin
         rst_cnt_ff <= rst_cnt_ff + 21'h000001;
      end
   end
   // Next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         // Waiting for mode pin and software enable
         ST_STBY: begin
            if (s_run && ctrl_ff[`AFP_CTRL_EN]) begin
               nxt_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (delay_done) begin
               nxt_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (fault_any) begin   // New fault restarts the delay
               nxt_state = ST_DELAY;
            end else if (s_short == 2'b00) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fault_any || ocp_trip) begin
               nxt_state = ST_DELAY;
            end
         end
      endcase
      // Standby overrides everything
      if (!s_run || !ctrl_ff[`AFP_CTRL_EN]) begin
         nxt_state = ST_STBY;
      end
   end
   // State register and stage enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff    <= ST_STBY;
         stage_en_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         stage_en_ff <= (nxt_state == ST_RUN);
      end
   end
   // -------------------------------------------------
   // Cycle by cycle current limit and integrator
   // -------------------------------------------------
   // limit only, keep switching
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oc_prev_ff   <= 4'h0;
         force_off_ff <= 4'h0;
      end else begin
         oc_prev_ff <= s_oc;
         if (state_ff != ST_RUN || car_edge) begin
            force_off_ff <= 4'h0;
         end else begin
            force_off_ff <= force_off_ff | oc_evt;
         end
      end
   end
   // Only low impedance faults drain; refill once per clean cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prot_ff <= `AFP_PROT_FULL;
      end else if (state_ff != ST_RUN) begin
         prot_ff <= `AFP_PROT_FULL;
      end else if (oc_evt != 4'h0 && s_lowz) begin
         prot_ff <= (prot_ff > `AFP_PROT_DRAIN) ? prot_ff - `AFP_PROT_DRAIN : 8'h00;
      end else if (car_edge && force_off_ff == 4'h0) begin
         prot_ff <= (prot_ff < `AFP_PROT_FULL - `AFP_PROT_CHARGE) ?
                    prot_ff + `AFP_PROT_CHARGE : `AFP_PROT_FULL;
      end
   end
   // -------------------------------------------------
   // Thermal gain reduction
   // -------------------------------------------------
   // One dB per step, down when cooling below the band
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fold_cnt_ff <= 15'h0000;
         atten_ff    <= 4'h0;
      end else if (fold_off) begin
         fold_cnt_ff <= 15'h0000;
         atten_ff    <= 4'h0;
      end else if (fold_cnt_ff != 15'(FOLD_CYC - 1)) begin
         fold_cnt_ff <= fold_cnt_ff + 15'h0001;
      end else begin
         fold_cnt_ff <= 15'h0000;
         if (s_fold && !s_shut && atten_ff != `AFP_ATTEN_MAX) begin
            atten_ff <= atten_ff + 4'h1;
         end else if (!s_fold && atten_ff != 4'h0) begin
            atten_ff <= atten_ff - 4'h1;
         end
      end
   end
   // -------------------------------------------------
   // Wishbone slave
   // -------------------------------------------------
   // Control register, low byte lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `AFP_CTRL_RST;
      end else if (wr_hit && wb_adr_i == {28'h0000000, `AFP_OFS_CTRL}) begin
         ctrl_ff <= wb_dat_i[1:0];
      end
   end
   // Sticky faults; a new event wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sticky_ff <= 6'h00;
      end else if (wr_hit && wb_adr_i == {28'h0000000, `AFP_OFS_FAULT}) begin
         sticky_ff <= (sticky_ff & ~wb_dat_i[5:0]) | flt_now;
      end else begin
         sticky_ff <= sticky_ff | flt_now;
      end
   end
   // One wait state; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff  <= wb_cyc_i & wb_stb_i & ~ack_ff;
         rdat_ff <= 32'h00000000;
         if (wb_adr_i[31:4] == 28'h0000000) begin
            unique case (wb_adr_i[3:0])
               `AFP_OFS_CTRL:   rdat_ff <= {30'h00000000, ctrl_ff};
               `AFP_OFS_STATUS: rdat_ff <= {16'h0000, s_short, flt_now, atten_ff,
                                            s_fold, stage_en_ff, state_ff};
               `AFP_OFS_FAULT:  rdat_ff <= {26'h0000000, sticky_ff};
               `AFP_OFS_PROT:   rdat_ff <= {24'h000000, prot_ff};
               default:         rdat_ff <= 32'h00000000;
            endcase
         end
      end
   end
   // -------------------------------------------------
   // Outputs
   // -------------------------------------------------
   assign wb_dat_o     = rdat_ff;
   assign wb_ack_o     = ack_ff;
   assign stage_en_o   = stage_en_ff;
   assign force_off_o  = force_off_ff;
   assign force_on_o   = {force_off_ff[2], force_off_ff[3], force_off_ff[0], force_off_ff[1]};
   assign gain_atten_o = atten_ff;
endmodule

/* File: tb/afp_chk.sv */
// Purpose: Port-level assertions for the fault protection manager
// Assumes: RESTART_CYC equals that of the bound instance
// Notes:   Bound to every afp_top
`timescale 1ns/1ps
module afp_chk #(
   parameter int RESTART_CYC = 50
) (
   // Clock, reset and bus
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // Sensing pins
   input wire logic       temp_shut_i,
   input wire logic       uv_i,
   input wire logic       ov_i,
   input wire logic       mode_run_i,
   input wire logic       fold_dis_i,
   input wire logic       low_z_i,
   input wire logic [3:0] oc_i,
   // Stage control
   input wire logic       stage_en_o,
   input wire logic [3:0] force_off_o,
   input wire logic [3:0] force_on_o,
   input wire logic [3:0] gain_atten_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Quiet time since the last overtemperature, supply fault or standby
   // ----------------------------------------
   logic [31:0] quiet_ff;   // Saturates so it never wraps
   always_ff @(posedge clk_i) begin
      if (rst_i || temp_shut_i || uv_i || ov_i || !mode_run_i) begin
         quiet_ff <= 32'h0;
      end else if (quiet_ff != 32'hFFFFFFFF) begin
         quiet_ff <= quiet_ff + 32'h1;
      end
   end
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_heat_off: assert property (temp_shut_i [*5] |-> !stage_en_o)
      else $error("stages on at shutdown temperature");
   a_supply_off: assert property ((uv_i || ov_i) [*5] |-> !stage_en_o)
      else $error("stages on with supply out of range");
   a_restart_wait: assert property ($rose(stage_en_o) |-> quiet_ff >= RESTART_CYC)
      else $error("stages on before the restart delay");
   a_atten_max: assert property (gain_atten_o <= 4'hC)
      else $error("gain reduction beyond ceiling");
   a_atten_step: assert property (gain_atten_o > $past(gain_atten_o)
      |-> gain_atten_o == $past(gain_atten_o) + 4'h1)
      else $error("gain reduction not gradual");
   a_fold_pin: assert property (fold_dis_i [*5] |-> gain_atten_o == 4'h0)
      else $error("gain reduced while foldback disabled");
   a_force_pair: assert property (force_on_o ==
      {force_off_o[2], force_off_o[3], force_off_o[0], force_off_o[1]})
      else $error("complement switch not forced on");
   for (genvar k = 0; k < 4; k++) begin : g_oc
      a_oc_force: assert property ($rose(oc_i[k]) && stage_en_o && !low_z_i
         |-> ##[2:5] force_off_o[k])
         else $error("overcurrent did not turn its switch off");
   end
   c_start: cover property ($rose(stage_en_o));
   c_fold: cover property (gain_atten_o == 4'hC);
   c_clip: cover property (force_off_o != 4'h0);
endmodule

bind afp_top afp_chk #(.RESTART_CYC(RESTART_CYC)) i_afp_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .temp_shut_i(temp_shut_i), .uv_i(uv_i), .ov_i(ov_i),
   .mode_run_i(mode_run_i), .fold_dis_i(fold_dis_i), .low_z_i(low_z_i), .oc_i(oc_i),
   .stage_en_o(stage_en_o), .force_off_o(force_off_o), .force_on_o(force_on_o),
   .gain_atten_o(gain_atten_o));

/* File: tb/afp_sense_model.sv */
// Purpose: Carrier source and overcurrent sensors facing the manager
// Assumes: Carrier period of 20 system clocks
// Notes:   Pulses land in the carrier high phase, clear of carrier edges
`timescale 1ns/1ps
module afp_sense_model (
   // Clock and commands
   input  wire logic       clk_i,
   input  wire logic       car_on_i,   // Oscillator running
   input  wire logic [3:0] oc_req_i,   // Switches in overload
   // Sensed signals
   output logic            carrier_o,
   output logic [3:0]      oc_o
);
   logic [4:0] ph_ff;   // Carrier phase
   always_ff @(posedge clk_i) begin
      if (!car_on_i) begin
         ph_ff <= 5'h0;
      end else begin
         ph_ff <= (ph_ff == 5'h13) ? 5'h0 : ph_ff + 5'h1;
      end
   end
   // Low while stopped, so no stray edge appears
   always_comb carrier_o = car_on_i && (ph_ff < 5'hA);
   always_ff @(posedge clk_i) begin
      oc_o <= (car_on_i && (ph_ff == 5'h3 || ph_ff == 5'h4)) ? oc_req_i : 4'h0;
   end
endmodule

/* File: tb/amplifier_fault_protection_bench.sv */
// Purpose: Self-checking bench for the fault protection manager
// Assumes: Restart and foldback counts shortened by parameter
// Notes:   Expected sticky faults kept in a bench model
`timescale 1ns/1ps
`include "afp_regs.svh"
module amplifier_fault_protection_bench;
   import afp_pkg::*;
   localparam int RCYC = 50;   // Restart delay in cycles
   localparam int FCYC = 8;    // Cycles per dB step
   // Design inputs
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, temp_fold_i = 1'b0, temp_shut_i = 1'b0, low_z_i = 1'b0;
   logic        uv_i = 1'b0, ov_i = 1'b0, mode_run_i = 1'b0, fold_dis_i = 1'b0;
   logic        car_on = 1'b0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0;
   logic [3:0]  wb_sel_i = 4'h0, oc_req = 4'h0;
   logic [1:0]  rail_short_i = 2'h0;
   logic [7:0]  pos_rail = 8'h60, neg_rail = 8'h60;
   // Design outputs
   logic [31:0] wb_dat_o, q;
   logic        wb_ack_o, stage_en_o, carrier;
   logic [3:0]  force_off_o, force_on_o, gain_atten_o, oc;
   // Bench model
   int          n_fail = 0, total_checks = 0, seed, exp_flt, i, c;
   int          fq[$];   // Fault kinds still to run
   afp_top #(.RESTART_CYC(RCYC), .FOLD_CYC(FCYC)) i_afp_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .temp_fold_i(temp_fold_i), .temp_shut_i(temp_shut_i), .oc_i(oc), .low_z_i(low_z_i),
      .rail_short_i(rail_short_i), .uv_i(uv_i), .ov_i(ov_i), .mode_run_i(mode_run_i),
      .fold_dis_i(fold_dis_i), .carrier_i(carrier), .positive_analog_rail_i(pos_rail),
      .negative_analog_rail_i(neg_rail), .stage_en_o(stage_en_o),
      .force_off_o(force_off_o), .force_on_o(force_on_o), .gain_atten_o(gain_atten_o));
   afp_sense_model i_afp_sense_model (.clk_i(clk_i), .car_on_i(car_on), .oc_req_i(oc_req),
      .carrier_o(carrier), .oc_o(oc));
   always #25 clk_i = ~clk_i;
   // Compare one value
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Classic cycle; held until ack is seen
   task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         $display("Error at %0t: bus cycle never acknowledged", $time);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(q, e);
   endtask
   // Cycles until the stages reach level v
   task automatic wait_en(input logic v, output int n);
      n = 0;
      while (stage_en_o !== v && n < 400) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   // One overload, released once a switch is forced
   task automatic oc_hit(input logic [3:0] m);
      int n;
      n = 0;
      oc_req <= m;
      while (force_off_o === 4'h0 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      oc_req <= 4'h0;
   endtask
   task automatic set_flt(input int k, input logic v);
      case (k)
         `AFP_F_OTP: temp_shut_i <= v;
         `AFP_F_UV: uv_i <= v;
         `AFP_F_OV: ov_i <= v;
         `AFP_F_UBAL: pos_rail <= v ? 8'hFF : neg_rail;
         default: car_on <= !v;
      endcase
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 31;
      exp_flt = 0;
      fq = '{`AFP_F_OTP, `AFP_F_UV, `AFP_F_OV, `AFP_F_UBAL, `AFP_F_CLK};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(`AFP_OFS_CTRL, 32'h1);
      rchk(`AFP_OFS_STATUS, 32'h1000);
      rchk(`AFP_OFS_PROT, 32'hFF);
      wb(1'b1, 32'h10, $random(seed), 4'hF);
      rchk(32'h10, 32'h0);
      wb(1'b1, `AFP_OFS_CTRL, $random(seed), 4'hE);
      rchk(`AFP_OFS_CTRL, 32'h1);
      $display("Done: reset");
      q = $random(seed);
      pos_rail <= {2'b01, q[5:0]};
      neg_rail <= {2'b01, q[5:0]};
      rail_short_i <= 2'b01;
      mode_run_i <= 1'b1;
      car_on <= 1'b1;
      repeat (RCYC + 40) @(posedge clk_i);
      rchk(`AFP_OFS_STATUS, 32'h4002);
      rail_short_i <= 2'b00;
      wait_en(1'b1, c);
      chk(c < 12, 1'b1);
      rchk(`AFP_OFS_STATUS, 32'h7);
      wb(1'b1, `AFP_OFS_FAULT, 32'h3F, 4'h1);
      rchk(`AFP_OFS_FAULT, 32'h0);
      $display("Done: start-up");
      while (fq.size() > 0) begin
         i = fq.pop_front();
         set_flt(i, 1'b1);
         repeat ((i == `AFP_F_CLK) ? 240 : 8) @(posedge clk_i);
         chk(stage_en_o, 1'b0);
         exp_flt = exp_flt | (1 << i);
         rchk(`AFP_OFS_FAULT, exp_flt);
         set_flt(i, 1'b0);
         wait_en(1'b1, c);
         chk(c >= RCYC && c < RCYC + 12, 1'b1);
      end
      $display("Done: shutdown faults");
      temp_fold_i <= 1'b1;
      repeat (14 * FCYC) @(posedge clk_i);
      chk(gain_atten_o, 4'hC);
      fold_dis_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(gain_atten_o, 4'h0);
      fold_dis_i <= 1'b0;
      wb(1'b1, `AFP_OFS_CTRL, 32'h3, 4'h1);
      repeat (8) @(posedge clk_i);
      chk(gain_atten_o, 4'h0);
      chk(stage_en_o, 1'b1);
      wb(1'b1, `AFP_OFS_CTRL, 32'h1, 4'h1);
      temp_fold_i <= 1'b0;
      $display("Done: foldback");
      for (i = 0; i < 4; i++) begin
         oc_hit(4'h1 << i);
         chk(force_off_o, 4'h1 << i);
         chk(force_on_o, 4'h1 << (i ^ 1));
         repeat (24) @(posedge clk_i);
      end
      chk(stage_en_o, 1'b1);
      low_z_i <= 1'b1;
      oc_hit(4'h2);
      rchk(`AFP_OFS_PROT, 32'hDF);
      repeat (24) @(posedge clk_i);
      oc_req <= 4'h4;
      wait_en(1'b0, c);
      chk(c < 300, 1'b1);
      rail_short_i <= 2'b10;
      oc_req <= 4'h0;
      low_z_i <= 1'b0;
      exp_flt = exp_flt | (1 << `AFP_F_OCP);
      rchk(`AFP_OFS_FAULT, exp_flt);
      repeat (RCYC + 40) @(posedge clk_i);
      wb(1'b0, `AFP_OFS_STATUS, 32'h0, 4'hF);
      chk(q & 32'hC007, 32'h8002);
      rail_short_i <= 2'b00;
      wait_en(1'b1, c);
      chk(c < 12, 1'b1);
      repeat (RCYC + 20) @(posedge clk_i);
      chk(stage_en_o, 1'b1);
      $display("Done: overcurrent");
      wb(1'b1, `AFP_OFS_CTRL, 32'h0, 4'h1);
      repeat (2) @(posedge clk_i);
      chk(stage_en_o, 1'b0);
      $display("Done: standby");
      end_of_test();
   end
   // Watchdog, several times the expected run
   initial begin
      #(20000 * 50);
      n_fail++;
      end_of_test();
   end
endmodule
